// [debug_trace_pkg.sv]
// Constants, register layout and carrier types of the debug trace status block.
// Assumes a 32-bit Avalon-MM master and trace capture logic on the same clock.
package debug_trace_pkg;

    // ==================================================================
    // Bus geometry and register offsets.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;

    // ==================================================================
    // Control register fields and reset value.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PRIME_BIT = 1;
    localparam int CTRL_MODE_BIT = 2;
    localparam logic CTRL_ENABLE_RESET = 1'b0;
    localparam logic CTRL_PRIME_RESET = 1'b0;
    localparam logic CTRL_MODE_RESET = 1'b0;

    // ==================================================================
    // Status register fields and reset values.
    localparam int STAT_MATCH_A_BIT = 7;
    localparam int STAT_MATCH_B_BIT = 6;
    localparam int STAT_PRIMED_BIT = 5;
    localparam int STAT_UNUSED_BIT = 4;
    localparam int STAT_CNT_LSB = 0;
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b0;

    // ==================================================================
    // Trace storage depth in words.
    localparam int FIFO_DEPTH = 8;

    // ==================================================================
    // Carrier types.
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

    typedef struct packed {
        logic match_a;
        logic match_b;
        logic word_captured;
        logic word_read;
        logic trigger;
    } trace_evt_t;

endpackage

// [match_flag_cell.sv]
// Sticky match flag cleared by a run start and set by a comparator hit.
// Assumes both strobes are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
module match_flag_cell (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Events.
    input wire logic clear_pulse,
    input wire logic set_pulse,
    // Flag.
    output logic flag
);
    import debug_trace_pkg::*;

    logic flag_reg;
    logic flag_next;

    // ==================================================================
    // Flag update; a hit in the clearing cycle is kept.
    assign flag_next = set_pulse | (flag_reg & ~clear_pulse);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

    // ==================================================================
    // Checks.
    property p_set_wins;
        @(posedge ref_clk) disable iff (rst)
        set_pulse |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("match flag lost a hit");

    property p_clear_only;
        @(posedge ref_clk) disable iff (rst)
        (clear_pulse && !set_pulse) |=> !flag;
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("match flag not cleared");

endmodule

// [debug_trace_status.sv]
// Debug trace status block: control and status registers, run sequencing.
// Assumes comparators and trace storage strobe events on ref_clk.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

// Summary of operation
// - Status register is read only from bus.
// - Match A flag clears at run start.
// - Match B flag clears at run start.
// - Primed flag mirrors prime bit while enabled.
// - Prime write with enable starts run.
// - Hardware clears primed flag at run end.
// - Run ends on full in begin mode, on trigger in end mode.
// - Clearing prime or enable ends run.
// - Word count clears at start, holds at end.
// - Storage reads never decrement word count.
// - Word count is plain binary, zero to eight.
module debug_trace_status #(
    parameter int DEPTH = debug_trace_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus.
    input wire debug_trace_pkg::avmm_req_t avs_req,
    output logic [debug_trace_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Comparator and trace storage events.
    input wire debug_trace_pkg::trace_evt_t trace_evt,
    // Run state to capture logic.
    output logic trace_primed,
    output logic end_trace_mode,
    output logic run_start,
    output logic run_end
);
    import debug_trace_pkg::*;

    // ==================================================================
    // Elaboration check.
    if (DEPTH < 1 || DEPTH > 15) begin : g_depth_check
        $error("DEPTH must lie between 1 and 15");
    end

    localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(DEPTH - 1);

    typedef enum logic {RUN_IDLE, RUN_ACTIVE} run_state_t;

    run_state_t state_reg;
    run_state_t state_next;
    logic ack_reg;
    logic enable_reg;
    logic enable_next;
    logic prime_reg;
    logic prime_next;
    logic mode_reg;
    logic mode_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] readdata_next;
    logic match_a_flag;
    logic match_b_flag;

    // ==================================================================
    // Bus decode.
    wire bus_req = avs_req.read | avs_req.write;
    wire hit_ctrl = (avs_req.address == CTRL_OFS);
    wire hit_stat = (avs_req.address == STAT_OFS);
    wire wr_accept = avs_req.write & ack_reg;
    wire wr_ctrl = wr_accept & hit_ctrl & avs_req.byteenable[0];
    wire wr_stat = wr_accept & hit_stat;
    wire wr_enable = avs_req.writedata[CTRL_ENABLE_BIT];
    wire wr_prime = avs_req.writedata[CTRL_PRIME_BIT];
    wire wr_mode = avs_req.writedata[CTRL_MODE_BIT];

    assign avs_waitrequest = bus_req & ~ack_reg;

    // ==================================================================
    // Run control decode.
    wire is_active = (state_reg == RUN_ACTIVE);
    wire is_idle = (state_reg == RUN_IDLE);
    wire start_hit = wr_ctrl & wr_enable & wr_prime & is_idle;
    wire manual_end = is_active & wr_ctrl & (~wr_enable | ~wr_prime);
    wire fill_end = ~mode_reg & trace_evt.word_captured
                    & (count_reg == LAST_CNT);
    wire trig_end = mode_reg & trace_evt.trigger;
    wire hw_end = is_active & (fill_end | trig_end);
    wire end_hit = hw_end | manual_end;
    wire count_step = is_active & trace_evt.word_captured
                      & (count_reg < DEPTH_CNT);

    // ==================================================================
    // Next state of control register and run.
    assign enable_next = wr_ctrl ? wr_enable : enable_reg;
    assign mode_next = wr_ctrl ? wr_mode : mode_reg;
    assign prime_next = start_hit ? 1'b1
                        : (hw_end | (wr_ctrl & ~(wr_enable & wr_prime)))
                        ? 1'b0 : prime_reg;
    assign state_next = start_hit ? RUN_ACTIVE
                        : end_hit ? RUN_IDLE : state_reg;
    assign count_next = start_hit ? CNT_RESET
                        : count_step ? CNT_W'(count_reg + 4'h1)
                        : count_reg;

    // ==================================================================
    // Status word.
    // primed image
    wire primed_flag = enable_reg & prime_reg;
    wire [7:0] status_word = {match_a_flag, match_b_flag, primed_flag,
                              1'b0, count_reg};
    assign readdata_next = hit_ctrl
        ? {29'h0, mode_reg, prime_reg, enable_reg}
        : hit_stat ? {24'h0, status_word} : 32'h0;

    // ==================================================================
    // Registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (avs_req.read & ~ack_reg) begin
                readdata_reg <= readdata_next;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= RUN_IDLE;
            enable_reg <= CTRL_ENABLE_RESET;
            prime_reg <= CTRL_PRIME_RESET;
            mode_reg <= CTRL_MODE_RESET;
            count_reg <= CNT_RESET;
        end else begin
            state_reg <= state_next;
            enable_reg <= enable_next;
            prime_reg <= prime_next;
            mode_reg <= mode_next;
            count_reg <= count_next;
        end
    end

    // ==================================================================
    // Match flags.
    // match A
    match_flag_cell u_match_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear_pulse(start_hit),
        .set_pulse(is_active & trace_evt.match_a),
        .flag(match_a_flag)
    );

    match_flag_cell u_match_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear_pulse(start_hit),
        .set_pulse(is_active & trace_evt.match_b),
        .flag(match_b_flag)
    );

    // ==================================================================
    // Outputs.
    assign avs_readdata = readdata_reg;
    assign trace_primed = primed_flag;
    assign end_trace_mode = mode_reg;
    assign run_start = start_hit;
    assign run_end = end_hit;

    // ==================================================================
    // Checks.
    sequence s_fill_last;
        is_active && !mode_reg && trace_evt.word_captured
            && count_reg == LAST_CNT;
    endsequence

    sequence s_run_closed;
        !trace_primed && state_reg == RUN_IDLE;
    endsequence

    property p_status_ro;
        @(posedge ref_clk) disable iff (rst)
        (wr_stat && is_idle && !wr_ctrl) |=> $stable(status_word);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("status changed by a bus write");

    property p_start_clears_a;
        @(posedge ref_clk) disable iff (rst)
        start_hit |=> !match_a_flag;
    endproperty
    a_start_clears_a: assert property (p_start_clears_a)
        else $error("match A not cleared at run start");

    property p_start_clears_b;
        @(posedge ref_clk) disable iff (rst)
        start_hit |=> !match_b_flag;
    endproperty
    a_start_clears_b: assert property (p_start_clears_b)
        else $error("match B not cleared at run start");

    property p_primed_image;
        @(posedge ref_clk) disable iff (rst)
        trace_primed == (state_reg == RUN_ACTIVE);
    endproperty
    a_primed_image: assert property (p_primed_image)
        else $error("primed flag disagrees with run state");

    property p_start_arms;
        @(posedge ref_clk) disable iff (rst)
        start_hit |=> trace_primed && count_reg == 4'h0;
    endproperty
    a_start_arms: assert property (p_start_arms)
        else $error("run did not start");

    property p_fill_ends;
        @(posedge ref_clk) disable iff (rst)
        s_fill_last |=> s_run_closed ##0 (count_reg == DEPTH_CNT);
    endproperty
    a_fill_ends: assert property (p_fill_ends)
        else $error("full storage did not end the run");

    property p_trigger_ends;
        @(posedge ref_clk) disable iff (rst)
        (is_active && mode_reg && trace_evt.trigger) |=> s_run_closed;
    endproperty
    a_trigger_ends: assert property (p_trigger_ends)
        else $error("trigger did not end the run");

    property p_begin_no_trig;
        @(posedge ref_clk) disable iff (rst)
        (is_active && !mode_reg && trace_evt.trigger
            && !trace_evt.word_captured && !wr_ctrl) |=> trace_primed;
    endproperty
    a_begin_no_trig: assert property (p_begin_no_trig)
        else $error("trigger ended a begin-trace run");

    property p_end_clears;
        @(posedge ref_clk) disable iff (rst)
        run_end |=> !trace_primed;
    endproperty
    a_end_clears: assert property (p_end_clears)
        else $error("primed flag kept after run end");

    property p_manual_end;
        @(posedge ref_clk) disable iff (rst)
        manual_end |=> s_run_closed;
    endproperty
    a_manual_end: assert property (p_manual_end)
        else $error("manual stop did not end the run");

    property p_count_holds;
        @(posedge ref_clk) disable iff (rst)
        (is_idle && !start_hit) |=> $stable(count_reg);
    endproperty
    a_count_holds: assert property (p_count_holds)
        else $error("count moved outside a run");

    property p_read_no_dec;
        @(posedge ref_clk) disable iff (rst)
        (trace_evt.word_read && !trace_evt.word_captured && !start_hit)
            |=> $stable(count_reg);
    endproperty
    a_read_no_dec: assert property (p_read_no_dec)
        else $error("count changed on a storage read");

    property p_count_range;
        @(posedge ref_clk) disable iff (rst)
        count_reg <= DEPTH_CNT;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("count beyond storage depth");

    property p_bit4_zero;
        @(posedge ref_clk) disable iff (rst)
        (avs_req.read && !avs_waitrequest && hit_stat)
            |-> avs_readdata[STAT_UNUSED_BIT] == 1'b0;
    endproperty
    a_bit4_zero: assert property (p_bit4_zero)
        else $error("unused status bit read as one");

    property p_mode_taken;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> end_trace_mode == $past(wr_mode);
    endproperty
    a_mode_taken: assert property (p_mode_taken)
        else $error("mode setting not taken");

    property p_one_wait;
        @(posedge ref_clk) disable iff (rst)
        (bus_req && !ack_reg) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer not after one wait cycle");

endmodule

// [host_trace_model.sv]
// Model of the debug host and trace source beside the status block.
// Assumes the bench raises cmd for one ref_clk cycle per event.
`timescale 1ns/1ps
module host_trace_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Event requests from the bench.
    input wire debug_trace_pkg::trace_evt_t cmd,
    // Events toward the block and the host word tally.
    output debug_trace_pkg::trace_evt_t trace_evt,
    output logic [7:0] read_tally
);
    import debug_trace_pkg::*;

    assign trace_evt = cmd;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            read_tally <= 8'h00;
        end else if (cmd.word_read) begin
            read_tally <= read_tally + 8'h01;
        end
    end
endmodule

// [debug_trace_status_tb.sv]
// Self-checking bench of the debug trace status block.
// Assumes the host model drives all trace events.
`timescale 1ns/1ps
module debug_trace_status_tb;
    import debug_trace_pkg::*;

    // ==================================================================
    // Signals and constants.
    typedef struct packed {
        logic w;
        logic [3:0] a;
        logic [31:0] d;
        logic [31:0] q;
    } row_t;
    localparam logic [31:0] FA = 32'h1 << STAT_MATCH_A_BIT;
    localparam logic [31:0] FB = 32'h1 << STAT_MATCH_B_BIT;
    localparam logic [31:0] FP = 32'h1 << STAT_PRIMED_BIT;
    localparam logic [31:0] FULL = 32'(FIFO_DEPTH);
    localparam trace_evt_t E_A = 5'h10;
    localparam trace_evt_t E_B = 5'h08;
    localparam trace_evt_t E_C = 5'h04;
    localparam trace_evt_t E_R = 5'h02;
    localparam trace_evt_t E_T = 5'h01;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    avmm_req_t avs_req = '0;
    trace_evt_t cmd = '0;
    trace_evt_t trace_evt;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trace_primed;
    logic end_trace_mode;
    logic run_start;
    logic run_end;
    logic [7:0] read_tally;
    logic start_seen;
    logic end_seen;
    logic [31:0] q;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    row_t rows[4] = '{
        '{1'b1, STAT_OFS, 32'hff, 32'h0},
        '{1'b1, 4'h8, 32'hff, 32'h0},
        '{1'b1, CTRL_OFS, 32'h4, 32'h4},
        '{1'b1, CTRL_OFS, 32'h0, 32'h0}};

    always #5 ref_clk = ~ref_clk;

    debug_trace_status DUT (
        .ref_clk(ref_clk), .rst(rst), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trace_evt(trace_evt), .trace_primed(trace_primed),
        .end_trace_mode(end_trace_mode), .run_start(run_start),
        .run_end(run_end));

    host_trace_model host (
        .ref_clk(ref_clk), .rst(rst), .cmd(cmd),
        .trace_evt(trace_evt), .read_tally(read_tally));

    // ==================================================================
    // Tasks.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        r = '0;
        @(posedge ref_clk);
        avs_req <= '{read: !w, write: w, address: a, writedata: d,
                     byteenable: 4'hf};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        start_seen = run_start;
        r = avs_readdata;
        avs_req <= '0;
    endtask

    task automatic ev(input trace_evt_t e, input int k);
        repeat (k) begin
            @(posedge ref_clk);
            cmd <= e;
            @(negedge ref_clk);
            end_seen = run_end;
        end
        @(posedge ref_clk);
        cmd <= '0;
    endtask

    task automatic test_done;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    // ==================================================================
    // Main sequence.
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, q);
            bus(1'b0, rows[i].a, 32'h0, q);
            chk(q, rows[i].q);
        end
        $display("test registers done");
        bus(1'b1, CTRL_OFS, 32'h3, q);
        chk(start_seen, 32'h1);
        #1 chk(trace_primed, 32'h1);
        ev(E_A, 1);
        ev(E_C, 4);
        ev(E_R, 2);
        ev(E_C, 3);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FA | FP | 32'h7);
        ev(E_C, 1);
        chk(end_seen, 32'h1);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FA | FULL);
        ev(E_B, 1);
        ev(E_C, 1);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FA | FULL);
        $display("test begin run done");
        bus(1'b1, CTRL_OFS, 32'h3, q);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FP);
        ev(E_B, 1);
        bus(1'b1, CTRL_OFS, 32'h1, q);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FB);
        bus(1'b1, CTRL_OFS, 32'h7, q);
        #1 chk(end_trace_mode, 32'h1);
        ev(E_C, 10);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FP | FULL);
        ev(E_T, 1);
        chk(end_seen, 32'h1);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, FULL);
        $display("test end run done");
        bus(1'b1, CTRL_OFS, 32'h3, q);
        bus(1'b1, CTRL_OFS, 32'h2, q);
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, CTRL_OFS, 32'h0, q);
        chk(q, 32'h0);
        chk(read_tally, 32'h2);
        $display("test manual end done");
        bus(1'b1, CTRL_OFS, 32'h3, q);
        chk(start_seen, 32'h1);
        ev(E_A, 1);
        ev(E_T, 1);
        chk(end_seen, 32'h0);
        #1 chk(trace_primed, 32'h1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(trace_primed, 32'h0);
        rst <= 1'b0;
        bus(1'b0, STAT_OFS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, CTRL_OFS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, CTRL_OFS, 32'h3, q);
        chk(start_seen, 32'h1);
        $display("test reset done");
        test_done();
    end
endmodule
